/* include/dpt_defines.svh */
// Purpose: Offsets, field positions, reset values and codes of the dual-slope PWM timer
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes:   Included by the design files by bare name
`ifndef DPT_DEFINES_SVH
`define DPT_DEFINES_SVH

// ==========================================================================
// Register offsets
`define DPT_ADDR_CTRL    8'h00
`define DPT_ADDR_COUNT   8'h04
`define DPT_ADDR_CMPA    8'h08
`define DPT_ADDR_CMPB    8'h0C
`define DPT_ADDR_CAPTOP  8'h10
`define DPT_ADDR_FLAGS   8'h14
`define DPT_ADDR_PINS    8'h18

// ==========================================================================
// Control field positions
`define DPT_F_MODE       0
`define DPT_F_SELA       4
`define DPT_F_SELB       6
`define DPT_F_CLKSEL     8
`define DPT_F_DIRA       11
`define DPT_F_DIRB       12

// Flag bit positions
`define DPT_FL_OVF       0
`define DPT_FL_CMPA      1
`define DPT_FL_CMPB      2
`define DPT_FL_CAP       3

// ==========================================================================
// Reset values
`define DPT_RST_CTRL     13'h0000
`define DPT_RST_WORD     16'h0000
`define DPT_RST_FLAGS    4'h0

// ==========================================================================
// Mode codes
`define DPT_MODE_PC8     4'h1
`define DPT_MODE_PC9     4'h2
`define DPT_MODE_PC10    4'h3
`define DPT_MODE_PFC_CAP 4'h8
`define DPT_MODE_PFC_CMP 4'h9
`define DPT_MODE_PC_CAP  4'hA
`define DPT_MODE_PC_CMP  4'hB

// Fixed and limit TOP values
`define DPT_TOP_8BIT     16'h00FF
`define DPT_TOP_9BIT     16'h01FF
`define DPT_TOP_10BIT    16'h03FF
`define DPT_TOP_MIN      16'h0003
`define DPT_TOP_MAX      16'hFFFF

// Output select codes
`define DPT_SEL_OFF      2'h0
`define DPT_SEL_TOGGLE   2'h1
`define DPT_SEL_NONINV   2'h2
`define DPT_SEL_INV      2'h3

// ==========================================================================
// Prescaler tick masks (divider minus one)
`define DPT_PSC_MASK_1    10'h000
`define DPT_PSC_MASK_8    10'h007
`define DPT_PSC_MASK_64   10'h03F
`define DPT_PSC_MASK_256  10'h0FF
`define DPT_PSC_MASK_1024 10'h3FF

`endif

/* include/dpt_pkg.sv */
// Purpose: Types shared by the dual-slope PWM timer
// Assumes: Nothing beyond SystemVerilog
// Notes:   Constants live in dpt_defines.svh
package dpt_pkg;
    // ======================================================================
    // Count direction
    typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

    // One compare output pin: level and enable
    typedef struct packed {
        logic level;
        logic oe;
    } pin_t;

    // Software control fields
    typedef struct packed {
        logic       dirB;
        logic       dirA;
        logic [2:0] clkSel;
        logic [1:0] selB;
        logic [1:0] selA;
        logic [3:0] mode;
    } ctrl_t;
endpackage

/* src/dpt_prescaler.sv */
// Purpose: Timer tick enable from the reference clock
// Assumes: Select 0 or above 5 stops the timer
// Notes:   Tick is one reference cycle wide
`include "dpt_defines.svh"

module dpt_prescaler #(
    parameter int DIV_W = 10
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Divider choice and tick
    input  wire logic [2:0]       clkSel,
    output logic                  timerTick
);
    logic [DIV_W-1:0] divCnt;
    logic [DIV_W-1:0] next_divCnt;
    logic             next_timerTick;
    logic             run;
    logic [DIV_W-1:0] mask;

    // ======================================================================
    // Divider masks; free-running counter keeps phase between changes
    always_comb begin
        run  = 1'b1;
        mask = DIV_W'(`DPT_PSC_MASK_1);
        case (clkSel)
            3'h1: mask = DIV_W'(`DPT_PSC_MASK_1);
            3'h2: mask = DIV_W'(`DPT_PSC_MASK_8);
            3'h3: mask = DIV_W'(`DPT_PSC_MASK_64);
            3'h4: mask = DIV_W'(`DPT_PSC_MASK_256);
            3'h5: mask = DIV_W'(`DPT_PSC_MASK_1024);
            default: run = 1'b0;
        endcase
        next_divCnt    = divCnt + 1'b1;
        next_timerTick = run && ((divCnt & mask) == mask);
    end

    // Registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            divCnt    <= '0;
            timerTick <= 1'b0;
        end else begin
            divCnt    <= next_divCnt;
            timerTick <= next_timerTick;
        end
    end
endmodule

/* src/dpt_timer.sv */
// Purpose: Dual-slope 16-bit PWM timer with two compare units on Wishbone
// Assumes: Classic Wishbone, 32-bit data, single clock, synchronous reset
// Notes:   Only phase correct and phase and frequency correct modes count
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`include "dpt_defines.svh"

module dpt_timer (
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // Wishbone slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // Compare output pins
    output dpt_pkg::pin_t      compareOutputA,
    output dpt_pkg::pin_t      compareOutputB
);
    // ======================================================================
    // State
    dpt_pkg::ctrl_t ctrl;
    dpt_pkg::ctrl_t next_ctrl;
    dpt_pkg::dir_t  dir;
    dpt_pkg::dir_t  next_dir;
    logic [15:0]    counterValue;
    logic [15:0]    next_counterValue;
    logic [15:0]    compareA;
    logic [15:0]    next_compareA;
    logic [15:0]    compareB;
    logic [15:0]    next_compareB;
    logic [15:0]    bufA;
    logic [15:0]    next_bufA;
    logic [15:0]    bufB;
    logic [15:0]    next_bufB;
    logic [15:0]    captureTopValue;
    logic [15:0]    next_captureTopValue;
    logic [3:0]     flags;
    logic [3:0]     next_flags;
    logic           levA;
    logic           next_levA;
    logic           levB;
    logic           next_levB;
    dpt_pkg::pin_t  next_outA;
    dpt_pkg::pin_t  next_outB;
    logic [31:0]    next_wbDat;
    logic           next_wbAck;

    // Working terms
    logic           timerTick;
    logic           access;
    logic           wrEn;
    logic [31:0]    wrData;
    logic [31:0]    rdWord;
    logic [15:0]    top;
    logic           dual;
    logic           atTop;
    logic           atBot;
    logic           turnDown;
    logic           matchA;
    logic           matchB;
    logic           loadBuf;
    logic [3:0]     setFlags;
    logic [3:0]     clrFlags;

    // ======================================================================
    // Helpers
    function automatic logic isDual(input logic [3:0] m);
        return m == `DPT_MODE_PC8 || m == `DPT_MODE_PC9 || m == `DPT_MODE_PC10 ||
               m == `DPT_MODE_PC_CAP || m == `DPT_MODE_PC_CMP ||
               m == `DPT_MODE_PFC_CAP || m == `DPT_MODE_PFC_CMP;
    endfunction

    function automatic logic isFreqCorrect(input logic [3:0] m);
        return m == `DPT_MODE_PFC_CAP || m == `DPT_MODE_PFC_CMP;
    endfunction

    function automatic logic topFromCapture(input logic [3:0] m);
        return m == `DPT_MODE_PC_CAP || m == `DPT_MODE_PFC_CAP;
    endfunction

    function automatic logic topFromCompareA(input logic [3:0] m);
        return m == `DPT_MODE_PC_CMP || m == `DPT_MODE_PFC_CMP;
    endfunction

    // Resolution mask; fixed TOP values double as masks
    function automatic logic [15:0] topMask(input logic [3:0] m);
        case (m)
            `DPT_MODE_PC8:  return `DPT_TOP_8BIT;
            `DPT_MODE_PC9:  return `DPT_TOP_9BIT;
            `DPT_MODE_PC10: return `DPT_TOP_10BIT;
            default:        return `DPT_TOP_MAX;
        endcase
    endfunction

    // Next output level from select, match and slope
    function automatic logic waveLevel(input logic lev, input logic [1:0] sel,
                                       input logic hit, input logic down,
                                       input logic toggleOk);
        if (!hit) begin
            return lev;
        end
        case (sel)
            `DPT_SEL_TOGGLE: return toggleOk ? !lev : lev;
            `DPT_SEL_NONINV: return down;
            `DPT_SEL_INV:    return !down;
            default:         return lev;
        endcase
    endfunction

    // Pin driven only with an active select and direction set to output
    function automatic logic pinEnable(input logic [1:0] sel, input logic dirOut,
                                       input logic toggleOk);
        logic connected;
        connected = (sel == `DPT_SEL_NONINV) || (sel == `DPT_SEL_INV) ||
                    (sel == `DPT_SEL_TOGGLE && toggleOk);
        return connected && dirOut;
    endfunction

    // ======================================================================
    // Tick source
    dpt_prescaler #(
        .DIV_W     (10)
    ) u_prescaler (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clkSel    (ctrl.clkSel),
        .timerTick (timerTick)
    );

    // ======================================================================
    // Bus decode; access lasts one cycle, ack follows at the same edge
    always_comb begin
        access = wb_cyc_i && wb_stb_i && !wb_ack_o;
        wrEn   = access && wb_we_i;
        for (int i = 0; i < 4; i++) begin
            wrData[8*i +: 8] = wb_sel_i[i] ? wb_dat_i[8*i +: 8] : rdWord[8*i +: 8];
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdWord = 32'h0000_0000;
        case (wb_adr_i)
            `DPT_ADDR_CTRL:   rdWord = {19'h0_0000, ctrl};
            `DPT_ADDR_COUNT:  rdWord = {16'h0000, counterValue};
            `DPT_ADDR_CMPA:   rdWord = {16'h0000, bufA};
            `DPT_ADDR_CMPB:   rdWord = {16'h0000, bufB};
            `DPT_ADDR_CAPTOP: rdWord = {16'h0000, captureTopValue};
            `DPT_ADDR_FLAGS:  rdWord = {28'h000_0000, flags};
            `DPT_ADDR_PINS:   rdWord = {28'h000_0000, compareOutputB, compareOutputA};
            default:          rdWord = 32'h0000_0000;
        endcase
        next_wbAck = access;
        next_wbDat = access ? rdWord : 32'h0000_0000;
    end

    // ======================================================================
    // TOP selection and slope events
    always_comb begin
        dual = isDual(ctrl.mode);
        case (ctrl.mode)
            `DPT_MODE_PC8:  top = `DPT_TOP_8BIT;
            `DPT_MODE_PC9:  top = `DPT_TOP_9BIT;
            `DPT_MODE_PC10: top = `DPT_TOP_10BIT;
            default: begin
                // Capture or compare A; small values are lifted to the minimum
                top = topFromCapture(ctrl.mode) ? captureTopValue : compareA;
                if (top < `DPT_TOP_MIN) begin
                    top = `DPT_TOP_MIN;
                end
            end
        endcase
        atTop    = counterValue == top;
        atBot    = counterValue == 16'h0000;
        // At TOP the slope is already falling, at zero already rising
        turnDown = atTop || (dir == dpt_pkg::DIR_DOWN && !atBot);
        matchA   = dual && timerTick && counterValue == compareA;
        matchB   = dual && timerTick && counterValue == compareB;
        loadBuf  = dual && timerTick &&
                   (isFreqCorrect(ctrl.mode) ? atBot : atTop);
    end

    // ======================================================================
    // Counter, direction and compare registers
    always_comb begin
        next_counterValue = counterValue;
        next_dir          = dir;
        if (dual && timerTick) begin
            if (atTop) begin
                next_counterValue = counterValue - 1'b1;
                next_dir          = dpt_pkg::DIR_DOWN;
            end else if (atBot) begin
                next_counterValue = 16'h0001;
                next_dir          = dpt_pkg::DIR_UP;
            end else if (dir == dpt_pkg::DIR_UP) begin
                // Above a lowered TOP the count wraps through 0xFFFF
                next_counterValue = counterValue + 1'b1;
            end else begin
                next_counterValue = counterValue - 1'b1;
            end
        end
        if (wrEn && wb_adr_i == `DPT_ADDR_COUNT) begin
            next_counterValue = wrData[15:0];
        end

        next_ctrl = ctrl;
        if (wrEn && wb_adr_i == `DPT_ADDR_CTRL) begin
            next_ctrl = dpt_pkg::ctrl_t'(wrData[12:0]);
        end

        next_bufA = bufA;
        next_bufB = bufB;
        if (wrEn && wb_adr_i == `DPT_ADDR_CMPA) begin
            next_bufA = wrData[15:0] & topMask(ctrl.mode);
        end
        if (wrEn && wb_adr_i == `DPT_ADDR_CMPB) begin
            next_bufB = wrData[15:0] & topMask(ctrl.mode);
        end

        // Outside dual-slope modes the buffer is transparent
        next_compareA = compareA;
        next_compareB = compareB;
        if (loadBuf || !dual) begin
            next_compareA = bufA;
            next_compareB = bufB;
        end

        next_captureTopValue = captureTopValue;
        if (wrEn && wb_adr_i == `DPT_ADDR_CAPTOP) begin
            next_captureTopValue = wrData[15:0];
        end
    end

    // ======================================================================
    // Flags: hardware set beats a software write-one clear
    always_comb begin
        setFlags = 4'h0;
        setFlags[`DPT_FL_OVF]  = dual && timerTick && atBot;
        setFlags[`DPT_FL_CMPA] = matchA ||
                                 (dual && timerTick && atTop &&
                                  topFromCompareA(ctrl.mode));
        setFlags[`DPT_FL_CMPB] = matchB;
        setFlags[`DPT_FL_CAP]  = dual && timerTick && atTop &&
                                 topFromCapture(ctrl.mode);
        clrFlags = (wrEn && wb_adr_i == `DPT_ADDR_FLAGS) ? wrData[3:0] : 4'h0;
        next_flags = (flags & ~clrFlags) | setFlags;
    end

    // ======================================================================
    // Waveform levels and pin drive
    always_comb begin
        next_levA = waveLevel(levA, ctrl.selA, matchA, turnDown,
                              topFromCompareA(ctrl.mode));
        next_levB = waveLevel(levB, ctrl.selB, matchB, turnDown, 1'b0);
        next_outA.level = next_levA;
        next_outA.oe    = pinEnable(next_ctrl.selA, next_ctrl.dirA,
                                    topFromCompareA(next_ctrl.mode));
        next_outB.level = next_levB;
        next_outB.oe    = pinEnable(next_ctrl.selB, next_ctrl.dirB, 1'b0);
    end

    // ======================================================================
    // Registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl            <= dpt_pkg::ctrl_t'(`DPT_RST_CTRL);
            dir             <= dpt_pkg::DIR_UP;
            counterValue    <= `DPT_RST_WORD;
            compareA        <= `DPT_RST_WORD;
            compareB        <= `DPT_RST_WORD;
            bufA            <= `DPT_RST_WORD;
            bufB            <= `DPT_RST_WORD;
            captureTopValue <= `DPT_RST_WORD;
            flags           <= `DPT_RST_FLAGS;
            levA            <= 1'b0;
            levB            <= 1'b0;
            compareOutputA  <= '0;
            compareOutputB  <= '0;
            wb_dat_o        <= 32'h0000_0000;
            wb_ack_o        <= 1'b0;
        end else begin
            ctrl            <= next_ctrl;
            dir             <= next_dir;
            counterValue    <= next_counterValue;
            compareA        <= next_compareA;
            compareB        <= next_compareB;
            bufA            <= next_bufA;
            bufB            <= next_bufB;
            captureTopValue <= next_captureTopValue;
            flags           <= next_flags;
            levA            <= next_levA;
            levB            <= next_levB;
            compareOutputA  <= next_outA;
            compareOutputB  <= next_outB;
            wb_dat_o        <= next_wbDat;
            wb_ack_o        <= next_wbAck;
        end
    end
endmodule

/* bench/dpt_timer_assertions.sv */
// Purpose: Concurrent checks on the ports of the dual-slope PWM timer
// Assumes: Ack one cycle after the taking edge; pin enables registered
// Notes:   Bound to dpt_timer at the foot of this file
`include "dpt_defines.svh"

// ==========================================================================
// Checker
module dpt_timer_assertions (
    // Clock and reset
    input wire logic          ref_clk,
    input wire logic          rst_n,
    // Wishbone slave
    input wire logic          wb_cyc_i,
    input wire logic          wb_stb_i,
    input wire logic          wb_we_i,
    input wire logic [7:0]    wb_adr_i,
    input wire logic [3:0]    wb_sel_i,
    input wire logic [31:0]   wb_dat_i,
    input wire logic [31:0]   wb_dat_o,
    input wire logic          wb_ack_o,
    // Compare output pins
    input wire dpt_pkg::pin_t compareOutputA,
    input wire dpt_pkg::pin_t compareOutputB
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Control write taken at this edge, low two lanes enabled
    logic ctrlWr;
    assign ctrlWr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
                    wb_adr_i == `DPT_ADDR_CTRL && (&wb_sel_i[1:0]);

    // Bus handshake
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    // Reset must silence bus and pins whatever came before
    chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
        !wb_ack_o && compareOutputA == 2'h0 && compareOutputB == 2'h0)
        else $error("outputs active after reset edge");

    // Pin enables follow the control word at the same edge
    chk_sel_off: assert property (ctrlWr && wb_dat_i[5:4] == `DPT_SEL_OFF |-> ##2
        !compareOutputA.oe [*2]) else $error("pin A driven with select off");
    chk_dir_off: assert property (ctrlWr && !wb_dat_i[11] |-> ##2
        !compareOutputA.oe [*2]) else $error("pin A driven as input");
    chk_b_no_toggle: assert property (ctrlWr && wb_dat_i[7:6] == `DPT_SEL_TOGGLE |-> ##2
        !compareOutputB.oe [*2]) else $error("pin B driven in toggle select");

    // Main scenarios
    cover property (ctrlWr && wb_dat_i[3:0] == `DPT_MODE_PC_CMP);
    cover property ($rose(compareOutputB.level) && compareOutputB.oe);
    cover property ($fell(compareOutputA.level) && compareOutputA.oe);
endmodule

bind dpt_timer dpt_timer_assertions i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .compareOutputA(compareOutputA), .compareOutputB(compareOutputB));

/* bench/dpt_timer_tb_top.sv */
// Purpose: Self-checking bench for the dual-slope PWM timer
// Assumes: Ack comes one cycle after the taking edge
// Notes:   Pin timing is measured in reference cycles at falling edges
`include "dpt_defines.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errTotal++; \
    $display("FAIL %s exp %0h got %0h", nm, e, g); end end

module dpt_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ======================================================================
    // Stimulus and observation
    logic          refClk = 1'b0;
    logic          rstN   = 1'b0;
    logic          wbCyc  = 1'b0;
    logic          wbStb  = 1'b0;
    logic          wbWe   = 1'b0;
    logic [7:0]    wbAdr  = 8'h00;
    logic [3:0]    wbSel  = 4'h0;
    logic [31:0]   wbDatI = 32'h0000_0000;
    logic [31:0]   wbDatO;
    logic          wbAck;
    dpt_pkg::pin_t pinA;
    dpt_pkg::pin_t pinB;
    int            errTotal = 0;
    int            checked  = 0;

    // 100 MHz reference clock
    always #5 refClk = ~refClk;

    dpt_timer i_dpt_timer (.ref_clk(refClk), .rst_n(rstN), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .compareOutputA(pinA), .compareOutputB(pinB));

    // ======================================================================
    // Bus helpers; request held until ack is sampled, then dropped a cycle
    // No local limit: a missing ack is left to the watchdog
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge refClk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= a;
        wbSel  <= 4'hF;
        wbDatI <= d;
        do begin
            @(posedge refClk);
        end while (wbAck !== 1'b1);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    function automatic logic [31:0] ctl(logic [3:0] m, logic [1:0] sa, logic [1:0] sb,
                                        logic [2:0] ck, logic da, logic db);
        dpt_pkg::ctrl_t c;
        c = '{dirB: db, dirA: da, clkSel: ck, selB: sb, selA: sa, mode: m};
        return {19'h0_0000, c};
    endfunction

    // Cycles until the chosen pin level next changes
    task automatic span(input logic useB, output int n);
        logic l0;
        @(negedge refClk);
        l0 = useB ? pinB.level : pinA.level;
        // The entry edge already lies one cycle after the last change
        n = 1;
        do begin
            @(negedge refClk);
            n++;
        end while ((useB ? pinB.level : pinA.level) === l0 && n < 4000);
    endtask

    // Freeze the timer and park the counter at zero
    // TOP and compares are only rewritten while frozen, never mid-count
    task automatic stop();
        wr(`DPT_ADDR_CTRL, 32'h0000_0000);
        wr(`DPT_ADDR_COUNT, 32'h0000_0000);
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] q;
        wb(1'b0, `DPT_ADDR_CTRL, 32'h0, q);
        `CHK("ctrl reset", 32'h0000_0000, q)
        wb(1'b0, `DPT_ADDR_FLAGS, 32'h0, q);
        `CHK("flags reset", 32'h0000_0000, q)
        wr(8'h1C, 32'hFFFF_FFFF);
        wb(1'b0, 8'h1C, 32'h0, q);
        `CHK("unmapped read", 32'h0000_0000, q)
    endtask

    // Fixed TOP masks compare writes to the resolution
    task automatic t_mask();
        logic [31:0] q;
        logic [15:0] tops[3] = '{`DPT_TOP_8BIT, `DPT_TOP_9BIT, `DPT_TOP_10BIT};
        for (int m = 0; m < 3; m++) begin
            wr(`DPT_ADDR_CTRL, ctl(4'(m + 1), `DPT_SEL_OFF, `DPT_SEL_OFF, 3'h0, 1'b1, 1'b1));
            wr(`DPT_ADDR_CMPB, 32'h0000_FFFF);
            wb(1'b0, `DPT_ADDR_CMPB, 32'h0, q);
            `CHK("masked compare", {16'h0000, tops[m]}, q)
            wb(1'b0, `DPT_ADDR_PINS, 32'h0, q);
            `CHK("pin A enable", 1'b0, q[0])
        end
    endtask

    // Toggle on TOP=3 gives a half period of 6 ticks at dividers 1, 8 and 64,
    // in both compare-A TOP modes; pin B stays undriven in toggle select
    task automatic t_toggle();
        int n;
        int divs[3] = '{1, 8, 64};
        stop();
        wr(`DPT_ADDR_CMPA, 32'h0000_0003);
        for (int i = 0; i < 3; i++) begin
            wr(`DPT_ADDR_CTRL, ctl(i == 1 ? `DPT_MODE_PFC_CMP : `DPT_MODE_PC_CMP,
                                   `DPT_SEL_TOGGLE, `DPT_SEL_TOGGLE, 3'(i + 1), 1'b1, 1'b1));
            span(1'b0, n);
            span(1'b0, n);
            span(1'b0, n);
            `CHK("toggle half period", 6 * divs[i], n)
            `CHK("pin A enable", 1'b1, pinA.oe)
            `CHK("pin B toggle enable", 1'b0, pinB.oe)
        end
    endtask

    // TOP=10 from capture, compare 4: low 12 and high 8 ticks when non-inverted
    task automatic t_pwm();
        int n;
        int e;
        logic [31:0] q;
        logic [3:0] modes[2] = '{`DPT_MODE_PFC_CAP, `DPT_MODE_PC_CAP};
        logic [1:0] sels[2] = '{`DPT_SEL_NONINV, `DPT_SEL_INV};
        for (int k = 0; k < 4; k++) begin
            stop();
            wr(`DPT_ADDR_CAPTOP, 32'h0000_000A);
            wr(`DPT_ADDR_CMPB, 32'h0000_0004);
            wr(`DPT_ADDR_FLAGS, 32'h0000_000F);
            wb(1'b0, `DPT_ADDR_FLAGS, 32'h0, q);
            `CHK("flags cleared", 4'h0, q[3:0])
            wr(`DPT_ADDR_CTRL, ctl(modes[k[1]], `DPT_SEL_OFF, sels[k[0]], 3'h1, 1'b0, 1'b1));
            span(1'b1, n);
            for (int j = 0; j < 2; j++) begin
                span(1'b1, n);
                e = ((pinB.level === 1'b1) == (sels[k[0]] == `DPT_SEL_NONINV)) ? 12 : 8;
                `CHK("pwm phase length", e, n)
            end
            wb(1'b0, `DPT_ADDR_FLAGS, 32'h0, q);
            `CHK("flags after period", 4'hF, q[3:0])
        end
    endtask

    // Compare at zero or TOP holds the output constant
    task automatic t_extreme();
        int bad;
        logic ex;
        for (int k = 0; k < 4; k++) begin
            stop();
            wr(`DPT_ADDR_CAPTOP, 32'h0000_000A);
            wr(`DPT_ADDR_CMPB, k[0] ? 32'h0000_000A : 32'h0000_0000);
            wr(`DPT_ADDR_CTRL, ctl(`DPT_MODE_PFC_CAP, `DPT_SEL_OFF,
                k[1] ? `DPT_SEL_INV : `DPT_SEL_NONINV, 3'h1, 1'b0, 1'b1));
            ex = k[0] ^ k[1];
            bad = 0;
            repeat (25) @(negedge refClk);
            repeat (40) begin
                @(negedge refClk);
                if (pinB.level !== ex) bad++;
            end
            `CHK("constant level", 0, bad)
            `CHK("pin B enable", 1'b1, pinB.oe)
        end
    endtask

    // ======================================================================
    // Verdict and end of run
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge refClk);
        rstN <= 1'b1;
        t_reset();
        t_mask();
        t_toggle();
        t_pwm();
        t_extreme();
        final_report();
    end

    // Watchdog; the run needs well under half this span
    initial begin
        repeat (40000) @(posedge refClk);
        errTotal++;
        final_report();
    end
endmodule
